/* hw/als_pkg.sv */
// shared constants and types for the light sensor command link and its bus master
//
// Contract
// - device holds three-bit exposure time code
// - codes 000/001/010 select 400/200/100 ms; default 001
// - 011 test, 100 simulation; 101-111 never selected
// - only single-byte writes and single-byte reads
// - sixteen-bit count fetched as two byte reads
// - device answers only at bus address 0x39
// - command 0x00 starts a light conversion
// - command 0x03 completes conversion, latches count
// - command 0x43 makes next read return low byte
// - command 0x83 makes next read return high byte
// - master sends start, complete, select, read, select, read
// - command 0x1D clears exposure code bit zero
// - 0x88 sets bit one, 0x90 sets bit two
// - command 0x18 restores exposure code to 001
// - device acknowledges its address and each data byte
// - master ends the read byte with not-acknowledge, stop
// - no repeated start; stop ends every transaction
package als_pkg;

  localparam logic [6:0] DEV_ADDR = 7'h39;

  localparam logic [7:0] CMD_CONV_START = 8'h00;
  localparam logic [7:0] CMD_CONV_DONE = 8'h03;
  localparam logic [7:0] CMD_CLR_BIT0 = 8'h1D;
  localparam logic [7:0] CMD_EXP_DEFAULT = 8'h18;
  localparam logic [7:0] CMD_SEL_LOW = 8'h43;
  localparam logic [7:0] CMD_SEL_HIGH = 8'h83;
  localparam logic [7:0] CMD_SET_BIT1 = 8'h88;
  localparam logic [7:0] CMD_SET_BIT2 = 8'h90;

  localparam logic [2:0] EXP_400MS = 3'h0;
  localparam logic [2:0] EXP_200MS = 3'h1;
  localparam logic [2:0] EXP_100MS = 3'h2;
  localparam logic [2:0] EXP_TEST = 3'h3;
  localparam logic [2:0] EXP_SIM = 3'h4;
  localparam logic [2:0] EXP_RESET = EXP_200MS;

  localparam logic [19:0] INT_400MS_US = 20'd400000;
  localparam logic [19:0] INT_200MS_US = 20'd200000;
  localparam logic [19:0] INT_100MS_US = 20'd100000;
  localparam logic [19:0] INT_TEST_US = 20'd16700;
  localparam logic [19:0] INT_SIM_US = 20'd1000;

  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_READ = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;

  localparam int CLK_PERIOD_NS = 10;
  // fast mode keeps one transaction near five thousand cycles
  localparam int SCL_PERIOD_NS = 2500;
  localparam int T_BUF_NS = 1300;
  // quarter rounded up so the bus clock never runs above its rate
  localparam logic [8:0] QUARTER_CYCLES =
    9'((SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS));
  localparam logic [8:0] T_BUF_CYCLES = 9'((T_BUF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_ADDR = 3'b001,
    D_ACK_WAIT = 3'b010,
    D_ACK_HOLD = 3'b011,
    D_WDATA = 3'b100,
    D_RDATA = 3'b101,
    D_RACK = 3'b110,
    D_WAIT_STOP = 3'b111
  } dev_state_t;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_BIT = 3'b010,
    M_STOP = 3'b011,
    M_GAP = 3'b100
  } host_state_t;

endpackage

/* hw/als_bus_if.sv */
// two-wire bus carrier joining the light sensor and its master
`timescale 1ns/10ps
interface als_bus_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic s_sda_o;
  logic s_sda_oe_n;
  logic sda;

  // open drain with pull-up: a party pulls low only while its enable is low
  assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);

  modport device (input scl, input sda, output s_sda_o, output s_sda_oe_n);
  modport host (output scl, output m_sda_o, output m_sda_oe_n, input sda);
endinterface

/* hw/als_device.sv */
// light sensor command slave: bus protocol, command decode, exposure code, count readout
`timescale 1ns/10ps
module als_device
  import als_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // serial bus
  als_bus_if.device bus,
  // converter side
  input wire logic [15:0] adc_count,
  output logic conv_start,
  output logic conv_complete,
  output logic converting,
  output logic [2:0] exposure_time_code,
  output logic [19:0] integration_us
);

  typedef struct packed {
    dev_state_t st;
    logic scl_q;
    logic sda_q;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic rw;
    logic after_data;
    logic sda_oe_n;
    logic sel_high;
    logic [15:0] count;
    logic [2:0] exp;
    logic [19:0] integ;
    logic start_p;
    logic done_p;
    logic busy;
  } dev_regs_t;

  localparam dev_regs_t DEV_RESET = '{
    st: D_IDLE,
    scl_q: 1'b1,
    sda_q: 1'b1,
    shreg: 8'h00,
    bitcnt: 3'h0,
    rw: 1'b0,
    after_data: 1'b0,
    sda_oe_n: 1'b1,
    sel_high: 1'b0,
    count: 16'h0000,
    exp: EXP_RESET,
    integ: INT_200MS_US,
    start_p: 1'b0,
    done_p: 1'b0,
    busy: 1'b0
  };

  dev_regs_t r_reg;
  dev_regs_t r_next;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;

  ////////////////////////////////////////////////////////////////////////////
  // bus conditions, seen against the previous sample of both lines

  assign scl_rise = bus.scl & ~r_reg.scl_q;
  assign scl_fall = ~bus.scl & r_reg.scl_q;
  assign bus_start = bus.scl & r_reg.scl_q & r_reg.sda_q & ~bus.sda;
  assign bus_stop = bus.scl & r_reg.scl_q & ~r_reg.sda_q & bus.sda;
  assign rx_byte = {r_reg.shreg[6:0], bus.sda};
  assign tx_byte = r_reg.sel_high ? r_reg.count[15:8] : r_reg.count[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    r_next = r_reg;
    r_next.scl_q = bus.scl;
    r_next.sda_q = bus.sda;
    r_next.start_p = 1'b0;
    r_next.done_p = 1'b0;

    unique case (r_reg.st)
      D_IDLE:
      begin
        r_next.sda_oe_n = 1'b1;
      end

      D_ADDR:
      begin
        if (scl_rise)
        begin
          r_next.shreg = rx_byte;
          r_next.bitcnt = r_reg.bitcnt + 3'h1;
          if (r_reg.bitcnt == 3'h7)
          begin
            r_next.rw = bus.sda;
            r_next.after_data = 1'b0;
            // foreign address: stay off the bus until the next start
            if (r_reg.shreg[6:0] == DEV_ADDR)
              r_next.st = D_ACK_WAIT;
            else
              r_next.st = D_WAIT_STOP;
          end
        end
      end

      D_ACK_WAIT:
      begin
        // pull low only once the clock is low, so no false start is seen
        if (scl_fall)
        begin
          r_next.sda_oe_n = 1'b0;
          r_next.st = D_ACK_HOLD;
        end
      end

      D_ACK_HOLD:
      begin
        if (scl_fall)
        begin
          r_next.sda_oe_n = 1'b1;
          r_next.bitcnt = 3'h0;
          if (r_reg.after_data)
            r_next.st = D_WAIT_STOP;
          else if (r_reg.rw)
          begin
            r_next.shreg = tx_byte;
            r_next.sda_oe_n = tx_byte[7];
            r_next.st = D_RDATA;
          end
          else
            r_next.st = D_WDATA;
        end
      end

      D_WDATA:
      begin
        if (scl_rise)
        begin
          r_next.shreg = rx_byte;
          r_next.bitcnt = r_reg.bitcnt + 3'h1;
          if (r_reg.bitcnt == 3'h7)
          begin
            r_next.after_data = 1'b1;
            r_next.st = D_ACK_WAIT;
            case (rx_byte)
              CMD_CONV_START:
              begin
                r_next.start_p = 1'b1;
                r_next.busy = 1'b1;
              end
              CMD_CONV_DONE:
              begin
                r_next.count = adc_count;
                r_next.done_p = 1'b1;
                r_next.busy = 1'b0;
              end
              CMD_SEL_LOW: r_next.sel_high = 1'b0;
              CMD_SEL_HIGH: r_next.sel_high = 1'b1;
              CMD_CLR_BIT0: r_next.exp[0] = 1'b0;
              CMD_SET_BIT1: r_next.exp[1] = 1'b1;
              CMD_SET_BIT2: r_next.exp[2] = 1'b1;
              CMD_EXP_DEFAULT: r_next.exp = EXP_RESET;
              default: r_next.exp = r_reg.exp;
            endcase
          end
        end
      end

      D_RDATA:
      begin
        if (scl_fall)
        begin
          if (r_reg.bitcnt == 3'h7)
          begin
            r_next.sda_oe_n = 1'b1;
            r_next.st = D_RACK;
          end
          else
          begin
            r_next.shreg = {r_reg.shreg[6:0], 1'b0};
            r_next.sda_oe_n = r_reg.shreg[6];
            r_next.bitcnt = r_reg.bitcnt + 3'h1;
          end
        end
      end

      D_RACK:
      begin
        // one byte only: even an acknowledge from the master ends the data
        if (scl_rise)
          r_next.st = D_WAIT_STOP;
      end

      D_WAIT_STOP:
      begin
        r_next.sda_oe_n = 1'b1;
      end
    endcase

    // bus conditions override any phase; a start mid-frame restarts decode
    if (bus_start)
    begin
      r_next.st = D_ADDR;
      r_next.bitcnt = 3'h0;
      r_next.sda_oe_n = 1'b1;
    end
    else if (bus_stop)
    begin
      r_next.st = D_IDLE;
      r_next.sda_oe_n = 1'b1;
    end

    // reserved codes leave the duration at zero, no conversion is timed
    unique case (r_next.exp)
      EXP_400MS: r_next.integ = INT_400MS_US;
      EXP_200MS: r_next.integ = INT_200MS_US;
      EXP_100MS: r_next.integ = INT_100MS_US;
      EXP_TEST: r_next.integ = INT_TEST_US;
      EXP_SIM: r_next.integ = INT_SIM_US;
      default: r_next.integ = 20'h0_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      r_reg <= DEV_RESET;
    else
      r_reg <= r_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe_n = r_reg.sda_oe_n;
  assign conv_start = r_reg.start_p;
  assign conv_complete = r_reg.done_p;
  assign converting = r_reg.busy;
  assign exposure_time_code = r_reg.exp;
  assign integration_us = r_reg.integ;

endmodule

/* hw/als_host.sv */
// bus master for the light sensor: register port in, single-byte transactions out
`timescale 1ns/10ps
module als_host
  import als_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // serial bus
  als_bus_if.host bus,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);

  typedef struct packed {
    host_state_t st;
    logic [8:0] cnt;
    logic [1:0] phase;
    logic [3:0] bitn;
    logic second;
    logic is_read;
    logic [7:0] cmd;
    logic [8:0] tx;
    logic [8:0] rx;
    logic [7:0] rd_byte;
    logic nack;
    logic busy;
    logic scl_o;
    logic sda_oe_n;
    logic [7:0] rdata;
  } host_regs_t;

  localparam host_regs_t HOST_RESET = '{
    st: M_IDLE,
    cnt: 9'h000,
    phase: 2'h0,
    bitn: 4'h0,
    second: 1'b0,
    is_read: 1'b0,
    cmd: 8'h00,
    tx: 9'h1FF,
    rx: 9'h000,
    rd_byte: 8'h00,
    nack: 1'b0,
    busy: 1'b0,
    scl_o: 1'b1,
    sda_oe_n: 1'b1,
    rdata: 8'h00
  };

  host_regs_t r_reg;
  host_regs_t r_next;

  always_comb
  begin
    r_next = r_reg;
    r_next.rdata = 8'h00;

    // a command written while busy is dropped; software polls busy first
    if (reg_wr && !r_reg.busy && (reg_addr == REG_CMD || reg_addr == REG_READ))
    begin
      r_next.cmd = reg_wdata;
      r_next.is_read = (reg_addr == REG_READ);
      r_next.busy = 1'b1;
      r_next.nack = 1'b0;
      r_next.st = M_START;
      r_next.phase = 2'h0;
      r_next.cnt = 9'h000;
    end

    if (reg_rd)
    begin
      case (reg_addr)
        REG_STATUS: r_next.rdata = {6'h00, r_reg.nack, r_reg.busy};
        REG_RDATA: r_next.rdata = r_reg.rd_byte;
        default: r_next.rdata = 8'h00;
      endcase
    end

    if (r_reg.st == M_GAP)
    begin
      // bus free time before another start may follow the stop
      r_next.cnt = r_reg.cnt + 9'h001;
      if (r_reg.cnt == T_BUF_CYCLES - 9'h001)
      begin
        r_next.st = M_IDLE;
        r_next.busy = 1'b0;
      end
    end
    else if (r_reg.st != M_IDLE)
    begin
      r_next.cnt = r_reg.cnt + 9'h001;
      if (r_reg.cnt == QUARTER_CYCLES - 9'h001)
      begin
        r_next.cnt = 9'h000;
        r_next.phase = r_reg.phase + 2'h1;
        unique case (r_reg.st)
          M_START:
          begin
            if (r_reg.phase == 2'h0)
              r_next.sda_oe_n = 1'b0;
            else
            begin
              r_next.scl_o = 1'b0;
              r_next.st = M_BIT;
              r_next.phase = 2'h0;
              r_next.tx = {DEV_ADDR, r_reg.is_read, 1'b1};
              r_next.bitn = 4'h0;
              r_next.second = 1'b0;
            end
          end
          M_BIT:
          begin
            unique case (r_reg.phase)
              2'h0: r_next.sda_oe_n = r_reg.tx[8];
              2'h1: r_next.scl_o = 1'b1;
              2'h2: r_next.rx = {r_reg.rx[7:0], bus.sda};
              2'h3:
              begin
                r_next.scl_o = 1'b0;
                r_next.tx = {r_reg.tx[7:0], 1'b1};
                r_next.bitn = r_reg.bitn + 4'h1;
                if (r_reg.bitn == 4'h8)
                begin
                  r_next.bitn = 4'h0;
                  if ((!r_reg.second || !r_reg.is_read) && r_reg.rx[0])
                  begin
                    r_next.nack = 1'b1;
                    r_next.st = M_STOP;
                  end
                  else if (!r_reg.second)
                  begin
                    r_next.second = 1'b1;
                    // read: all nine released, the last one is the not-acknowledge
                    r_next.tx = r_reg.is_read ? 9'h1FF : {r_reg.cmd, 1'b1};
                  end
                  else
                  begin
                    if (r_reg.is_read)
                      r_next.rd_byte = r_reg.rx[8:1];
                    r_next.st = M_STOP;
                  end
                end
              end
            endcase
          end
          M_STOP:
          begin
            unique case (r_reg.phase)
              2'h0: r_next.sda_oe_n = 1'b0;
              2'h1: r_next.scl_o = 1'b1;
              2'h2: r_next.sda_oe_n = 1'b1;
              2'h3:
              begin
                r_next.st = M_GAP;
                r_next.cnt = 9'h000;
              end
            endcase
          end
          default: r_next.st = r_reg.st;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      r_reg <= HOST_RESET;
    else
      r_reg <= r_next;
  end

  assign bus.scl = r_reg.scl_o;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe_n = r_reg.sda_oe_n;
  assign reg_rdata = r_reg.rdata;

endmodule

/* testbench/als_link_sva.sv */
// assertions on the two-wire link between the light sensor and its master
`timescale 1ns/10ps
module als_link_sva
  import als_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // bus lines
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_oe_n,
  input wire logic s_sda_oe_n
);
  logic scl_q;
  logic sda_q;
  logic [4:0] bc;
  logic [7:0] ab;
  logic [9:0] gap;
  logic [10:0] tail;
  logic rise;
  logic start;
  logic stop;
  assign rise = scl & ~scl_q;
  assign start = scl & scl_q & sda_q & ~sda;
  assign stop = scl & scl_q & ~sda_q & sda;
  //////////////////////////////////////////////////
  // frame decode: bits since start, first byte, cycles since stop
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bc <= 5'h00;
      ab <= 8'h00;
      gap <= 10'h3ff;
      tail <= 11'h000;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (start)
        bc <= 5'h00;
      else if (rise)
        bc <= bc + 5'h01;
      if (rise && bc < 5'h08)
        ab <= {ab[6:0], sda};
      // saturates so a long idle never wraps into a false short gap
      if (stop)
        gap <= 10'h000;
      else if (gap != 10'h3ff)
        gap <= gap + 10'h001;
      // cycles since the last bit of a full frame, cleared by its stop
      if (stop)
        tail <= 11'h000;
      else if (rise && bc == 5'h11)
        tail <= 11'h001;
      else if (tail != 11'h000 && tail != 11'h7ff)
        tail <= tail + 11'h001;
    end
  end
  //////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  addr_ack_a: assert property (rise && bc == 5'h08 && ab[7:1] == DEV_ADDR |-> !sda)
    else $error("own address not acknowledged");
  wdata_ack_a: assert property (rise && bc == 5'h11 && !ab[0] |-> !sda)
    else $error("written byte not acknowledged");
  read_nack_a: assert property (rise && bc == 5'h11 && ab[0] |-> sda)
    else $error("read byte not ended by release");
  // the clock rise after the last bit may only be the one of the stop
  one_byte_a: assert property (rise && bc >= 5'h12 |-> ##[1:200] stop)
    else $error("more than one byte in a transaction");
  dev_edge_a: assert property ($changed(s_sda_oe_n) |-> !scl)
    else $error("device moved data while clock high");
  ack_hold_a: assert property ($fell(s_sda_oe_n) |-> !s_sda_oe_n throughout (##[1:1000] $rose(scl)))
    else $error("device let go of data before clock rise");
  bus_free_a: assert property (start |-> !m_sda_oe_n && gap >= 10'(T_BUF_CYCLES))
    else $error("start too soon after stop");
  stop_end_a: assert property (tail < 11'h640)
    else $error("no stop after last bit");
endmodule

/* testbench/ambient_light_cmd_readout_tb_top.sv */
// self-checking bench: master and sensor joined over the two-wire link
`timescale 1ns/10ps
module ambient_light_cmd_readout_tb_top
  import als_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rstn;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic [15:0] adc_count;
  logic conv_start;
  logic conv_complete;
  logic converting;
  logic [2:0] exposure_time_code;
  logic [19:0] integration_us;
  logic [7:0] rv;
  int errors;
  int tests_run;
  int n_start = 0;
  int n_done = 0;
  als_bus_if bus_i();
  als_device i_als_device (.sys_clk(sys_clk), .rstn(rstn), .bus(bus_i.device),
    .adc_count(adc_count), .conv_start(conv_start), .conv_complete(conv_complete),
    .converting(converting), .exposure_time_code(exposure_time_code),
    .integration_us(integration_us));
  als_host i_als_host (.sys_clk(sys_clk), .rstn(rstn), .bus(bus_i.host), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  als_link_sva i_als_link_sva (.sys_clk(sys_clk), .rstn(rstn), .scl(bus_i.scl), .sda(bus_i.sda),
    .m_sda_oe_n(bus_i.m_sda_oe_n), .s_sda_oe_n(bus_i.s_sda_oe_n));
  always #5 sys_clk = ~sys_clk;
  // pulses stand one cycle, so they are counted rather than sampled
  always @(posedge sys_clk)
  begin
    if (conv_start === 1'b1)
      n_start++;
    if (conv_complete === 1'b1)
      n_done++;
  end
  //////////////////////////////////////////////////
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic wait_idle(output logic [7:0] st);
    int n;
    n = 0;
    st = 8'h01;
    @(posedge sys_clk);
    while (st[0] !== 1'b0)
    begin
      if (n == 4000)
      begin
        errors++;
        $display("BAD t=%0t seen=%h exp=%h", $time, st, 8'h00);
        summarize();
      end
      reg_read(REG_STATUS, st);
      n++;
    end
  endtask
  // every transaction must finish with busy and nack both clear
  task automatic cmd(input logic [7:0] c);
    logic [7:0] st;
    reg_write(REG_CMD, c);
    wait_idle(st);
    check(20'(st), 20'h0_0000);
  endtask
  // one read transaction of the selected byte, then the byte the master kept
  task automatic fetch(output logic [7:0] d);
    logic [7:0] st;
    reg_write(REG_READ, 8'h00);
    wait_idle(st);
    check(20'(st), 20'h0_0000);
    reg_read(REG_RDATA, d);
  endtask
  //////////////////////////////////////////////////
  initial
  begin
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    adc_count = 16'ha55a;
    errors = 0;
    tests_run = 0;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
    check(20'(exposure_time_code), 20'(EXP_RESET));
    check(integration_us, INT_200MS_US);
    check(20'(converting), 20'h0_0000);
    reg_write(8'h10, 8'h55);
    reg_read(8'h10, rv);
    check(20'(rv), 20'h0_0000);
    reg_read(REG_STATUS, rv);
    check(20'(rv), 20'h0_0000);
    $display("test reset done");
    cmd(CMD_SET_BIT1);
    check(20'(exposure_time_code), 20'(EXP_TEST));
    check(integration_us, INT_TEST_US);
    cmd(CMD_CLR_BIT0);
    check(20'(exposure_time_code), 20'(EXP_100MS));
    check(integration_us, INT_100MS_US);
    cmd(CMD_EXP_DEFAULT);
    check(20'(exposure_time_code), 20'(EXP_RESET));
    check(integration_us, INT_200MS_US);
    cmd(CMD_CLR_BIT0);
    check(20'(exposure_time_code), 20'(EXP_400MS));
    check(integration_us, INT_400MS_US);
    // path kept clear of the reserved codes 101 to 111
    cmd(CMD_SET_BIT2);
    check(20'(exposure_time_code), 20'(EXP_SIM));
    check(integration_us, INT_SIM_US);
    $display("test exposure done");
    cmd(CMD_CONV_START);
    check(20'(n_start), 20'h0_0001);
    check(20'(converting), 20'h0_0001);
    cmd(CMD_CONV_DONE);
    adc_count <= 16'h0ff0;
    check(20'(n_done), 20'h0_0001);
    check(20'(converting), 20'h0_0000);
    $display("test conversion done");
    cmd(CMD_SEL_LOW);
    fetch(rv);
    check(20'(rv), 20'h0_005a);
    cmd(CMD_SEL_HIGH);
    fetch(rv);
    check(20'(rv), 20'h0_00a5);
    $display("test readout done");
    // an unknown command leaves code, conversion and byte select alone
    cmd(8'h55);
    check(20'(exposure_time_code), 20'(EXP_SIM));
    check(20'(integration_us), 20'(INT_SIM_US));
    check(20'(converting), 20'h0_0000);
    fetch(rv);
    check(20'(rv), 20'h0_00a5);
    $display("test unknown done");
    summarize();
  end
endmodule
